// file: rtl/svd_map.svh
/*
 * Register offsets, field positions, reset values and timing counts for the
 * supply-voltage threshold detector.
 * Assumes inclusion by bare name from the design module, the checker and the testbench.
 */
`ifndef SVD_MAP_SVH
`define SVD_MAP_SVH

// APB byte offsets, one aligned word each
`define SVD_OFF_CTRL        12'h000
`define SVD_OFF_CORE_IRQ    12'h004
`define SVD_OFF_FLAGS_TWO   12'h008
`define SVD_OFF_ENABLES_TWO 12'h00C
`define SVD_OFF_PRIO_TWO    12'h010
`define SVD_OFF_STATUS      12'h014
`define SVD_OFF_MASK        12'h018

// Control register fields
`define SVD_BIT_DIR         7
`define SVD_BIT_STABLE      5
`define SVD_BIT_ENABLE      4
`define SVD_LEVEL_HI        3
`define SVD_LEVEL_EXT       4'hF
`define SVD_CTRL_RESET      8'h05
`define SVD_CTRL_WMASK      8'h9F

// Flag, enable and priority bit of the voltage event, and global interrupt enable bit
`define SVD_BIT_EVENT       2
`define SVD_BIT_GIE         7

// Status/mask register bits
`define SVD_ST_EVENT        0
`define SVD_ST_STABLE       1
`define SVD_ST_WAKE         2
`define SVD_ST_W            3

// Settling interval in ns, and clock period in ns
`define SVD_SETTLE_NS       20000
`define SVD_CLK_NS          8

`endif

// file: rtl/svd_pkg.sv
/*
 * Types of the supply-voltage threshold detector.
 * Assumes svd_map.svh on the include path.
 */
package svd_pkg;
	typedef enum logic [1:0] {
		SVD_OFF,
		SVD_SETTLING,
		SVD_ARMED
	} svd_state_t;
	typedef logic [3:0] svd_level_t;
endpackage

// file: rtl/svd_detect.sv
/*
 * APB register slave and event logic of the supply-voltage threshold
 * detector: control register, event flag, interrupt enables and wake.
 * Assumes the analog comparator, divider and reference sit outside and
 * report a crossing level synchronous to sys_clk; the core reads the
 * interrupt and wake outputs.
 */
`timescale 1ns/1ns
`include "svd_map.svh"

module svd_detect #(
	parameter int SETTLE_NS = `SVD_SETTLE_NS,
	parameter int SETTLE_CYCLES = (SETTLE_NS + `SVD_CLK_NS - 1) / `SVD_CLK_NS
) (
	input  wire logic              sys_clk,
	input  wire logic              resetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic [31:0]            prdata,
	input  wire logic              supply_above_trip,
	input  wire logic              supply_below_trip,
	input  wire logic              sleep_mode,
	output logic                   detector_power,
	output svd_pkg::svd_level_t    trip_level_select,
	output logic                   external_trip_input_sel,
	output logic                   trip_direction_select,
	output logic                   voltage_irq_req,
	output logic                   voltage_irq_high_prio,
	output logic                   wake_request,
	output logic                   irq
);
	import svd_pkg::*;

	localparam int CW = $clog2(SETTLE_CYCLES + 1);

	svd_state_t  state;
	svd_state_t  next_state;
	logic [7:0]  ctrl;
	logic [7:0]  core_irq;
	logic [7:0]  flags_two;
	logic [7:0]  enables_two;
	logic [7:0]  prio_two;
	logic [`SVD_ST_W-1:0] status;
	logic [`SVD_ST_W-1:0] mask;
	logic [CW-1:0] settle_cnt;
	logic        wake;

	// APB strobes: always ready, one access cycle
	wire access   = psel & penable;
	wire wr       = access & pwrite;
	wire rd       = access & ~pwrite;
	wire hit_ctrl = paddr == `SVD_OFF_CTRL;
	wire hit_core = paddr == `SVD_OFF_CORE_IRQ;
	wire hit_flg  = paddr == `SVD_OFF_FLAGS_TWO;
	wire hit_en   = paddr == `SVD_OFF_ENABLES_TWO;
	wire hit_pri  = paddr == `SVD_OFF_PRIO_TWO;
	wire hit_st   = paddr == `SVD_OFF_STATUS;
	wire hit_msk  = paddr == `SVD_OFF_MASK;
	wire mapped   = hit_ctrl | hit_core | hit_flg | hit_en | hit_pri |
	                hit_st | hit_msk;

	// Control fields
	wire enable    = ctrl[`SVD_BIT_ENABLE];
	wire stable    = state == SVD_ARMED;
	wire dir_rise  = ctrl[`SVD_BIT_DIR];
	wire [7:0] ctrl_wdata = pwdata[7:0] & `SVD_CTRL_WMASK;
	// A write that sets enable from clear restarts settling
	wire en_rise = wr & hit_ctrl & ctrl_wdata[`SVD_BIT_ENABLE] & ~enable;

	// Crossing condition; events held off until settled
	wire crossing = dir_rise ? supply_above_trip : supply_below_trip;
	wire event_set = stable & enable & crossing;

	// Settling sequencer
	always_comb begin
		next_state = state;
		case (state)
			SVD_OFF: begin
				if (enable)
					next_state = SVD_SETTLING;
			end
			SVD_SETTLING: begin
				if (!enable)
					next_state = SVD_OFF;
				else if (settle_cnt == CW'(SETTLE_CYCLES - 1))
					next_state = SVD_ARMED;
			end
			SVD_ARMED: begin
				if (!enable)
					next_state = SVD_OFF;
			end
			default: next_state = SVD_OFF;
		endcase
		if (en_rise)
			next_state = SVD_SETTLING;
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state      <= SVD_OFF;
			settle_cnt <= '0;
		end else begin
			state      <= next_state;
			settle_cnt <= (next_state == SVD_SETTLING &&
			               state == SVD_SETTLING) ?
			              settle_cnt + CW'(1) : '0;
		end
	end

	// Control register; stable bit shown live, bit 6 never stored
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			ctrl <= `SVD_CTRL_RESET;
		else if (wr && hit_ctrl)
			ctrl <= ctrl_wdata;
	end

	// Event flag: hardware set wins over software clear
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			flags_two <= 8'h00;
		else if (event_set)
			flags_two[`SVD_BIT_EVENT] <= 1'b1;
		else if (wr && hit_flg)
			flags_two[`SVD_BIT_EVENT] <= pwdata[`SVD_BIT_EVENT];
	end

	// Enable, priority and core interrupt control bits
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			enables_two <= 8'h00;
			prio_two    <= 8'h00;
			core_irq    <= 8'h00;
			mask        <= '0;
		end else begin
			if (wr && hit_en)
				enables_two[`SVD_BIT_EVENT] <= pwdata[`SVD_BIT_EVENT];
			if (wr && hit_pri)
				prio_two[`SVD_BIT_EVENT] <= pwdata[`SVD_BIT_EVENT];
			if (wr && hit_core)
				core_irq[`SVD_BIT_GIE] <= pwdata[`SVD_BIT_GIE];
			if (wr && hit_msk)
				mask <= pwdata[`SVD_ST_W-1:0];
		end
	end

	// Sticky status: events set, a read clears, set wins
	wire [`SVD_ST_W-1:0] st_events = {
		wake,
		state == SVD_SETTLING && next_state == SVD_ARMED,
		event_set & ~flags_two[`SVD_BIT_EVENT]
	};
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			status <= '0;
		else
			status <= ((rd && hit_st) ? '0 : status) | st_events;
	end

	// Interrupt request and wake
	wire flag_en = flags_two[`SVD_BIT_EVENT] & enables_two[`SVD_BIT_EVENT];
	wire next_req = flag_en & core_irq[`SVD_BIT_GIE];
	// Wake does not need the global enable; the core decides vectoring
	wire next_wake = sleep_mode & flags_two[`SVD_BIT_EVENT];
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			voltage_irq_req       <= 1'b0;
			voltage_irq_high_prio <= 1'b0;
			wake                  <= 1'b0;
			irq                   <= 1'b0;
		end else begin
			voltage_irq_req       <= next_req;
			voltage_irq_high_prio <= next_req & prio_two[`SVD_BIT_EVENT];
			wake                  <= next_wake;
			irq                   <= |(status & mask);
		end
	end
	assign wake_request = wake;

	// Analog-side controls
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			detector_power          <= 1'b0;
			trip_level_select       <= 4'h5;
			external_trip_input_sel <= 1'b0;
			trip_direction_select   <= 1'b0;
		end else begin
			detector_power          <= enable;
			trip_level_select       <= ctrl[`SVD_LEVEL_HI:0];
			external_trip_input_sel <=
				ctrl[`SVD_LEVEL_HI:0] == `SVD_LEVEL_EXT;
			trip_direction_select   <= dir_rise;
		end
	end

	// Read mux; status read side effect is above
	wire [7:0] ctrl_view = {ctrl[7], 1'b0, stable, ctrl[4:0]};
	wire [31:0] rdata =
		hit_ctrl ? {24'h000000, ctrl_view} :
		hit_core ? {24'h000000, core_irq} :
		hit_flg  ? {24'h000000, flags_two} :
		hit_en   ? {24'h000000, enables_two} :
		hit_pri  ? {24'h000000, prio_two} :
		hit_st   ? {{(32-`SVD_ST_W){1'b0}}, status} :
		hit_msk  ? {{(32-`SVD_ST_W){1'b0}}, mask} : 32'h00000000;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			prdata <= 32'h00000000;
		else if (psel && !penable && !pwrite)
			prdata <= rdata;
	end

	assign pready  = 1'b1;
	assign pslverr = access & ~mapped;
endmodule // svd_detect

// file: tb/svd_detect_assertions.sv
/* Checker of the voltage detector ports.
 Assumes binding to svd_detect and offsets from svd_map.svh. */
`timescale 1ns/1ns
`include "svd_map.svh"
module svd_detect_chk (
	input logic        sys_clk, resetn, psel, penable, pwrite,
	input logic [11:0] paddr,
	input logic [31:0] pwdata, prdata,
	input logic        sleep_mode, detector_power, wake_request,
	input logic [3:0]  trip_level_select,
	input logic        external_trip_input_sel, trip_direction_select,
	input logic        voltage_irq_req, irq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	// Completed control accesses
	wire acc = psel && penable;
	wire wr_c = acc && pwrite && paddr == `SVD_OFF_CTRL;
	wire rd_c = acc && !pwrite && paddr == `SVD_OFF_CTRL;
	// Direction output is registered behind the control register
	dir_sel_a: assert property (wr_c |=> ##1
		trip_direction_select == $past(pwdata[7], 2)) else $error("dir");
	rsvd_bit_a: assert property (rd_c |->
		prdata[31:8] == 0 && !prdata[6]) else $error("reserved bit");
	// Settled flag only while powered, so disable drops it
	stable_a: assert property (rd_c && prdata[5] |-> prdata[4])
		else $error("stable without enable");
	power_a: assert property (wr_c |=> ##1
		detector_power == $past(pwdata[4], 2)) else $error("power");
	level_a: assert property (wr_c |=> ##1
		trip_level_select == $past(pwdata[3:0], 2)) else $error("level");
	ext_sel_a: assert property (external_trip_input_sel ==
		(trip_level_select == `SVD_LEVEL_EXT)) else $error("ext sel");
	wake_a: assert property (wake_request |-> $past(sleep_mode))
		else $error("wake while awake");
	reset_val_a: assert property ($rose(resetn) |->
		trip_level_select == 4'h5 && !detector_power) else $error("rst");
	cover property (voltage_irq_req);
	cover property (wake_request);
	cover property (irq);
endmodule // svd_detect_chk
bind svd_detect svd_detect_chk u_chk (.sys_clk, .resetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .sleep_mode,
	.detector_power, .wake_request, .trip_level_select,
	.external_trip_input_sel, .trip_direction_select,
	.voltage_irq_req, .irq);

// file: tb/tb_svd_detect.sv
/* Testbench of the voltage detector: APB tasks and scenarios.
 Assumes svd_map.svh on the include path; settling shortened to 80 ns. */
`timescale 1ns/1ns
`include "svd_map.svh"
module tb_svd_detect;
	logic        sys_clk = 0, resetn = 0, psel = 0, penable = 0;
	logic        pwrite = 0, above = 0, below = 0, sleep_mode = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, rd, prdata;
	logic        pready, pslverr, irq, wake, vreq, pwr, ext, dir;
	int          fails = 0, compares = 0;
	always #4 sys_clk = ~sys_clk;
	svd_detect #(.SETTLE_NS(80)) DUT (.sys_clk, .resetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
		.supply_above_trip(above), .supply_below_trip(below),
		.sleep_mode, .detector_power(pwr), .trip_level_select(),
		.external_trip_input_sel(ext), .trip_direction_select(dir),
		.voltage_irq_req(vreq), .voltage_irq_high_prio(),
		.wake_request(wake), .irq);
	task print_verdict;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// One APB transfer; request held until pready seen at an edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge sys_clk) penable <= 1;
		repeat (9) begin
			@(posedge sys_clk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		psel <= 0; penable <= 0;
		if (pready !== 1'b1) begin
			fails++;
			print_verdict;
		end
	endtask
	task t_ctrl;
		apb(0, `SVD_OFF_CTRL, 0); chk(rd, 'h05);
		apb(1, `SVD_OFF_CTRL, 'hFF); apb(0, `SVD_OFF_CTRL, 0);
		chk(rd, 'h9F);
		@(negedge sys_clk) chk({pwr, ext, dir}, 3'b111);
		repeat (12) @(posedge sys_clk);
		apb(0, `SVD_OFF_CTRL, 0); chk(rd, 'hBF);
		apb(1, `SVD_OFF_CTRL, 'h0F); apb(0, `SVD_OFF_CTRL, 0);
		chk(rd, 'h0F);
		apb(1, `SVD_OFF_CTRL, 'h1F); apb(0, `SVD_OFF_CTRL, 0);
		chk(rd, 'h1F);
		$display("ctrl test done");
	endtask
	// Crossing during settling must stay hidden until stable
	task t_event;
		@(posedge sys_clk) below <= 1;
		apb(0, `SVD_OFF_FLAGS_TWO, 0); chk(rd, 0);
		repeat (12) @(posedge sys_clk);
		apb(0, `SVD_OFF_FLAGS_TWO, 0); chk(rd, 4);
		apb(1, `SVD_OFF_ENABLES_TWO, 4);
		apb(1, `SVD_OFF_CORE_IRQ, 'h80);
		// Request is registered one cycle after the enabling write
		@(posedge sys_clk);
		@(negedge sys_clk) chk(vreq, 1);
		apb(1, `SVD_OFF_CORE_IRQ, 0);
		@(posedge sys_clk);
		@(negedge sys_clk) chk(vreq, 0);
		apb(1, `SVD_OFF_FLAGS_TWO, 0); apb(0, `SVD_OFF_FLAGS_TWO, 0);
		chk(rd, 4);
		below <= 0; above <= 1;
		apb(1, `SVD_OFF_FLAGS_TWO, 0); apb(0, `SVD_OFF_FLAGS_TWO, 0);
		chk(rd, 0);
		apb(1, `SVD_OFF_CTRL, 'h9F); apb(0, `SVD_OFF_FLAGS_TWO, 0);
		chk(rd, 4);
		$display("event test done");
	endtask
	task t_irq;
		// Interrupt output lags the mask or status change by one cycle
		apb(1, `SVD_OFF_MASK, 1);
		@(posedge sys_clk);
		@(negedge sys_clk) chk(irq, 1);
		apb(1, `SVD_OFF_MASK, 0);
		@(posedge sys_clk);
		@(negedge sys_clk) chk(irq, 0);
		apb(1, `SVD_OFF_MASK, 1); apb(0, `SVD_OFF_STATUS, 0);
		@(posedge sys_clk);
		@(negedge sys_clk) chk({rd[0], irq}, 2'b10);
		@(posedge sys_clk) sleep_mode <= 1;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk) chk(wake, 1);
		apb(0, 'h100, 0); chk(rd, 0);
		@(posedge sys_clk) resetn <= 0;
		@(posedge sys_clk) resetn <= 1;
		apb(0, `SVD_OFF_CTRL, 0); chk(rd, 'h05);
		$display("irq test done");
	endtask
	initial begin
		repeat (2) @(posedge sys_clk);
		resetn <= 1;
		t_ctrl;
		t_event;
		t_irq;
		print_verdict;
	end
endmodule // tb_svd_detect
